// file: rtl/prt_pkg.sv
// constants and types shared by the processor status monitor
package prt_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_P1_CUR  = 8'h67;
    localparam logic [7:0] ADDR_P1_AVG  = 8'h68;
    localparam logic [7:0] ADDR_P2_CUR  = 8'h69;
    localparam logic [7:0] ADDR_P2_AVG  = 8'h6a;
    localparam logic [7:0] ADDR_GPI     = 8'h6b;
    localparam logic [7:0] ADDR_P1_CODE = 8'h6c;

    // ==========================================================
    // reset values
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;

    // ==========================================================
    // field layout of the code register
    localparam int CODE_SIX_MSB   = 5;
    localparam int CODE_SEVEN_MSB = 6;
    localparam int CODE_TOP_MSB   = 7;
    localparam int CODE_TOP_LSB   = 1;

    // ==========================================================
    // throttle measurement scale: 256 steps per interval
    localparam logic [7:0] LAST_SLOT = 8'hff;
    localparam logic [8:0] QUO_FULL  = 9'h100;
    localparam logic [7:0] VAL_MAX   = 8'hff;
    localparam logic [7:0] VAL_MIN   = 8'h01;

    // ==========================================================
    // code stability time
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int STABLE_TIME_NS  = 600;
    localparam int STABLE_CYCLES   = (STABLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [6:0] STABLE_LAST = 7'(STABLE_CYCLES - 1);

    // ==========================================================
    // code register layouts
    typedef enum logic [1:0] {
        LEGACY_SIX_BIT_MODE,
        LEGACY_EXTENDED_MODE,
        NEWER_REGULATOR_MODE_ONE,
        NEWER_REGULATOR_MODE_TWO
    } prt_mode_t;

endpackage : prt_pkg

// file: rtl/prt_throttle_meter.sv
// one throttle channel: active-time fraction and running average
`timescale 1ns/1ns
module prt_throttle_meter
    import prt_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // timing from the shared interval timer
    input  wire logic        activeSample,
    input  wire logic        restart,
    input  wire logic        intervalEnd,
    input  wire logic [15:0] stepLen,
    // results
    output logic      [7:0]  currentQ,
    output logic      [7:0]  averageQ
);

    logic [8:0]  quoQ, quoD;
    logic [15:0] remQ, remD;
    logic [7:0]  currentD, averageD, result;
    logic [8:0]  sum;
    logic [8:0]  quoAcc;
    logic [15:0] remAcc;

    // ==========================================================
    // accumulate samples, fold every stepLen into one step
    always_comb begin
        quoD     = quoQ;
        remD     = remQ;
        currentD = currentQ;
        averageD = averageQ;
        result   = RST_BYTE;
        sum      = 9'h000;
        if (activeSample) begin
            if (remQ + 16'h0001 >= stepLen) begin
                remD = RST_COUNT;
                quoD = (quoQ == QUO_FULL) ? quoQ : quoQ + 9'h001;
            end else begin
                remD = remQ + 16'h0001;
            end
        end
        // counts after this sample, before any clear
        quoAcc = quoD;
        remAcc = remD;
        // n means n/256, a partial first step reads one
        if (quoD >= QUO_FULL) result = VAL_MAX;
        else if (quoD == 9'h000 && remD != RST_COUNT) result = VAL_MIN;
        else result = quoD[7:0];
        sum = {1'b0, averageQ} + {1'b0, result};
        if (restart) begin
            quoD = 9'h000;
            remD = RST_COUNT;
        end else if (intervalEnd) begin
            currentD = result;
            averageD = sum[8:1];
            quoD     = 9'h000;
            remD     = RST_COUNT;
        end
    end

    // register stage
    always_ff @(posedge clock) begin
        if (rst) begin
            quoQ     <= 9'h000;
            remQ     <= RST_COUNT;
            currentQ <= RST_BYTE;
            averageQ <= RST_BYTE;
        end else begin
            quoQ     <= quoD;
            remQ     <= remD;
            currentQ <= currentD;
            averageQ <= averageD;
        end
    end

    // ==========================================================
    // checks
    avg_update_a: assert property (@(posedge clock) disable iff (rst)
        intervalEnd && !restart |=>
        averageQ == 8'((9'($past(averageQ)) + 9'(currentQ)) >> 1))
        else $error("average is not half of old average plus current");
    avg_timing_a: assert property (@(posedge clock) disable iff (rst)
        !$stable(averageQ) |-> $past(intervalEnd) && !$past(restart))
        else $error("average moved outside an interval end");
    min_step_a: assert property (@(posedge clock) disable iff (rst)
        intervalEnd && !restart && quoAcc == 9'h000 && remAcc != RST_COUNT |=>
        currentQ == VAL_MIN)
        else $error("small nonzero active time did not read one");
    write_keep_a: assert property (@(posedge clock) disable iff (rst)
        restart |=> currentQ == $past(currentQ) && quoQ == 9'h000)
        else $error("restart altered current value or kept samples");
    idle_hold_a: assert property (@(posedge clock) disable iff (rst)
        !activeSample && !restart && !intervalEnd |=>
        quoQ == $past(quoQ) && remQ == $past(remQ))
        else $error("inactive sample changed the count");
    active_step_a: assert property (@(posedge clock) disable iff (rst)
        activeSample && !restart && !intervalEnd && quoQ != QUO_FULL |=>
        quoQ != $past(quoQ) || remQ != $past(remQ))
        else $error("active sample was not counted");

endmodule : prt_throttle_meter

// file: rtl/prt_code_filter.sv
// stability filter for the voltage identification pins
`timescale 1ns/1ns
module prt_code_filter
    import prt_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // pins and filtered code
    input  wire logic [7:0] rawCode,
    output logic      [7:0] stableQ
);

    logic [7:0] prevQ, prevD, stableD;
    logic [6:0] countQ, countD;

    // ==========================================================
    // count cycles of unchanged pins, load once the time is met
    always_comb begin
        prevD   = rawCode;
        stableD = stableQ;
        if (rawCode != prevQ) countD = 7'h00;
        else if (countQ == STABLE_LAST) countD = countQ;
        else countD = countQ + 7'h01;
        if (countD == STABLE_LAST && countQ != STABLE_LAST) stableD = rawCode;
    end

    // register stage
    always_ff @(posedge clock) begin
        if (rst) begin
            prevQ   <= RST_BYTE;
            countQ  <= 7'h00;
            stableQ <= RST_BYTE;
        end else begin
            prevQ   <= prevD;
            countQ  <= countD;
            stableQ <= stableD;
        end
    end

    // ==========================================================
    // checks
    stable_load_a: assert property (@(posedge clock) disable iff (rst)
        !$stable(stableQ) |-> $past(countQ) == 7'(STABLE_CYCLES - 2)
        && stableQ == $past(rawCode))
        else $error("code loaded before the stability time");
    glitch_hold_a: assert property (@(posedge clock) disable iff (rst)
        rawCode != prevQ |=> $stable(stableQ))
        else $error("code moved on a changing pin sample");

endmodule : prt_code_filter

// file: rtl/prt_status_monitor.sv
// processor status monitor: throttle time, input levels, voltage code
`timescale 1ns/1ns

// Notes on behaviour
// - each average becomes (old average plus current value) halved
// - average updates in the same cycle as its current value
// - second current value loads its active fraction at each interval end
// - writing a current register keeps contents, restarts both intervals
// - value n means n/256; nonzero time below one step reads one
// - input state bit is one while its pin is low, live
// - mode field picks the layout of the code register
// - six-bit legacy mode shows code 5:0, bits 7:6 zero
// - extended and newer mode one show code 6:0, bit 7 zero
// - newer mode two shows code 7:1 in bits 7:1, bit 0 zero
// - code register loads only after pins hold for 600 ns
// - first current value behaves like the second one
module prt_status_monitor
    import prt_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // monitored pins
    input  wire logic        proc1ThrottleInN,
    input  wire logic        proc2ThrottleInN,
    input  wire logic [7:0]  generalInput,
    input  wire logic [7:0]  proc1VoltageCode,
    // settings held by registers outside this block
    input  wire logic [15:0] intervalStepCycles,
    input  wire logic [1:0]  codeMode,
    // register port
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    output logic      [7:0]  regRdData,
    output logic             regRdValid
);

    // ==========================================================
    // helper functions

    // a write here restarts both throttle intervals
    function automatic logic isRestartAddr(input logic [7:0] addr);
        isRestartAddr = (addr == ADDR_P1_CUR) || (addr == ADDR_P2_CUR);
    endfunction : isRestartAddr

    // place the filtered code in the layout of the chosen mode
    function automatic logic [7:0] mapCode(input logic [1:0] mode, input logic [7:0] code);
        logic [7:0] outCode;
        outCode = RST_BYTE;
        case (prt_mode_t'(mode))
            LEGACY_SIX_BIT_MODE: begin
                outCode = {2'b00, code[CODE_SIX_MSB:0]};
            end
            LEGACY_EXTENDED_MODE, NEWER_REGULATOR_MODE_ONE: begin
                outCode = {1'b0, code[CODE_SEVEN_MSB:0]};
            end
            NEWER_REGULATOR_MODE_TWO: begin
                outCode = {code[CODE_TOP_MSB:CODE_TOP_LSB], 1'b0};
            end
            default: begin
                outCode = RST_BYTE;
            end
        endcase
        mapCode = outCode;
    endfunction : mapCode

    // ==========================================================
    // declarations
    logic        restart;
    logic [15:0] stepLen;
    logic [15:0] stepCntQ, stepCntD;
    logic [7:0]  slotCntQ, slotCntD;
    logic        stepDone;
    logic        intervalEnd;
    logic [1:0]  throttleActive;
    logic [7:0]  currentVal [2];
    logic [7:0]  averageVal [2];
    logic [7:0]  stableCode;
    logic [7:0]  rdDataQ, rdDataD;
    logic        rdValidQ, rdValidD;

    // ==========================================================
    // register writes
    // contents are read-only; only the restart side effect remains
    assign restart = regWrEn && isRestartAddr(regAddr);

    // ==========================================================
    // interval timer, shared by both channels
    // an interval is 256 steps of stepLen clock cycles each
    assign stepLen  = (intervalStepCycles == RST_COUNT) ? 16'h0001 : intervalStepCycles;
    assign stepDone = (stepCntQ + 16'h0001 >= stepLen);
    // a restart in the last cycle wins over the interval end
    assign intervalEnd = stepDone && (slotCntQ == LAST_SLOT) && !restart;

    // next timer values
    always_comb begin
        stepCntD = stepCntQ;
        slotCntD = slotCntQ;
        if (restart) begin
            stepCntD = RST_COUNT;
            slotCntD = RST_BYTE;
        end else if (stepDone) begin
            stepCntD = RST_COUNT;
            slotCntD = slotCntQ + 8'h01;
        end else begin
            stepCntD = stepCntQ + 16'h0001;
        end
    end

    // timer registers
    always_ff @(posedge clock) begin
        if (rst) begin
            stepCntQ <= RST_COUNT;
            slotCntQ <= RST_BYTE;
        end else begin
            stepCntQ <= stepCntD;
            slotCntQ <= slotCntD;
        end
    end

    // ==========================================================
    // throttle channels
    // inputs are low-active, so a low pin is an active sample
    assign throttleActive = ~{proc2ThrottleInN, proc1ThrottleInN};

    // one meter per processor, same timing for both
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : gen_meter
            prt_throttle_meter u_meter (
                .clock        (clock),
                .rst          (rst),
                .activeSample (throttleActive[ch]),
                .restart      (restart),
                .intervalEnd  (intervalEnd),
                .stepLen      (stepLen),
                .currentQ     (currentVal[ch]),
                .averageQ     (averageVal[ch])
            );
        end
    endgenerate

    // ==========================================================
    // voltage code filter for the first processor
    prt_code_filter u_code (
        .clock   (clock),
        .rst     (rst),
        .rawCode (proc1VoltageCode),
        .stableQ (stableCode)
    );

    // ==========================================================
    // register reads
    // data is captured on the read strobe and held until the next
    always_comb begin
        rdDataD  = rdDataQ;
        rdValidD = regRdEn;
        if (regRdEn) begin
            case (regAddr)
                ADDR_P1_CUR:  rdDataD = currentVal[0];
                ADDR_P1_AVG:  rdDataD = averageVal[0];
                ADDR_P2_CUR:  rdDataD = currentVal[1];
                ADDR_P2_AVG:  rdDataD = averageVal[1];
                ADDR_GPI:     rdDataD = ~generalInput;
                ADDR_P1_CODE: rdDataD = mapCode(codeMode, stableCode);
                default:      rdDataD = RST_BYTE;
            endcase
        end
    end

    // read registers
    always_ff @(posedge clock) begin
        if (rst) begin
            rdDataQ  <= RST_BYTE;
            rdValidQ <= 1'b0;
        end else begin
            rdDataQ  <= rdDataD;
            rdValidQ <= rdValidD;
        end
    end

    assign regRdData  = rdDataQ;
    assign regRdValid = rdValidQ;

    // ==========================================================
    // checks on the interval timer
    interval_end_a: assert property (@(posedge clock) disable iff (rst)
        intervalEnd |-> slotCntQ == LAST_SLOT && stepCntQ == stepLen - 16'h0001)
        else $error("interval ended before its last step");

    restart_clear_a: assert property (@(posedge clock) disable iff (rst)
        restart |=> slotCntQ == RST_BYTE && stepCntQ == RST_COUNT)
        else $error("write to a current register did not restart timing");

    both_load_a: assert property (@(posedge clock) disable iff (rst)
        !$stable(currentVal[0]) || !$stable(currentVal[1]) |-> $past(intervalEnd))
        else $error("current value moved outside an interval end");

    sample_count_a: assert property (@(posedge clock) disable iff (rst)
        restart ##1 (proc2ThrottleInN && !restart && !intervalEnd) [*8] |=>
        currentVal[1] == $past(currentVal[1], 9))
        else $error("idle throttle input changed the current value");

    // ==========================================================
    // checks on register reads
    gpi_level_a: assert property (@(posedge clock) disable iff (rst)
        regRdEn && regAddr == ADDR_GPI |=> regRdData == ~$past(generalInput) && regRdValid)
        else $error("input state did not show inverted live pins");

    code_six_a: assert property (@(posedge clock) disable iff (rst)
        regRdEn && regAddr == ADDR_P1_CODE && codeMode == 2'b00 |=>
        regRdData == {2'b00, $past(stableCode[5:0])})
        else $error("six-bit layout is wrong");

    code_seven_a: assert property (@(posedge clock) disable iff (rst)
        regRdEn && regAddr == ADDR_P1_CODE && (codeMode == 2'b01 || codeMode == 2'b10) |=>
        regRdData == {1'b0, $past(stableCode[6:0])})
        else $error("seven-bit layout is wrong");

    code_top_a: assert property (@(posedge clock) disable iff (rst)
        regRdEn && regAddr == ADDR_P1_CODE && codeMode == 2'b11 |=>
        regRdData == {$past(stableCode[7:1]), 1'b0})
        else $error("upper seven-bit layout is wrong");

    mode_select_a: assert property (@(posedge clock) disable iff (rst)
        regRdEn && regAddr == ADDR_P1_CODE |=>
        regRdData == mapCode($past(codeMode), $past(stableCode)))
        else $error("code layout does not follow the mode field");

    unmapped_zero_a: assert property (@(posedge clock) disable iff (rst)
        regRdEn && (regAddr < ADDR_P1_CUR || regAddr > ADDR_P1_CODE) |=>
        regRdData == RST_BYTE)
        else $error("unmapped address did not read zero");

    // ==========================================================
    // checks on the register port
    rd_valid_a: assert property (@(posedge clock) disable iff (rst)
        regRdEn |=> regRdValid)
        else $error("read strobe gave no valid pulse");

    rd_pulse_a: assert property (@(posedge clock) disable iff (rst)
        !regRdEn |=> !regRdValid)
        else $error("valid pulse without a read strobe");

    rd_hold_a: assert property (@(posedge clock) disable iff (rst)
        !regRdEn |=> $stable(regRdData))
        else $error("read data moved without a read strobe");

    write_quiet_a: assert property (@(posedge clock) disable iff (rst)
        regWrEn && !regRdEn |=> $stable(regRdData) && !regRdValid)
        else $error("write disturbed the read port");

    // ==========================================================
    // checks on timer stepping
    step_hold_a: assert property (@(posedge clock) disable iff (rst)
        !restart && !stepDone |=> slotCntQ == $past(slotCntQ)
        && stepCntQ == $past(stepCntQ) + 16'h0001)
        else $error("step counter did not advance");

    slot_next_a: assert property (@(posedge clock) disable iff (rst)
        !restart && stepDone |=> stepCntQ == RST_COUNT
        && slotCntQ == $past(slotCntQ) + 8'h01)
        else $error("slot counter did not advance after a step");

    restart_keep_a: assert property (@(posedge clock) disable iff (rst)
        restart |=> $stable(averageVal[0]) && $stable(averageVal[1])
        && $stable(currentVal[0]) && $stable(currentVal[1]))
        else $error("write to a current register changed a result");

    // ==========================================================
    // check helper: cycles since the last restart or interval end
    // wide enough for 256 steps of the longest step length
    logic [23:0] sinceQ, sinceD;

    // count every cycle, clear where a new interval begins
    always_comb begin
        sinceD = sinceQ + 24'h00_0001;
        if (restart || intervalEnd) begin
            sinceD = 24'h00_0000;
        end
    end

    // helper register
    always_ff @(posedge clock) begin
        if (rst) begin
            sinceQ <= 24'h00_0000;
        end else begin
            sinceQ <= sinceD;
        end
    end

    interval_len_a: assert property (@(posedge clock) disable iff (rst)
        intervalEnd |-> sinceQ == {stepLen, 8'h00} - 24'h00_0001)
        else $error("interval ended early");

    interval_due_a: assert property (@(posedge clock) disable iff (rst)
        !restart && sinceQ == {stepLen, 8'h00} - 24'h00_0001 |-> intervalEnd)
        else $error("interval end is late");

endmodule : prt_status_monitor

// file: dv/prt_proc_model.sv
// processor and regulator pin model facing the status monitor
`timescale 1ns/1ns
module prt_proc_model (
    // clock
    input  wire logic       clock,
    // pins toward the monitor
    output logic            proc1ThrottleInN,
    output logic            proc2ThrottleInN,
    output logic      [7:0] generalInput,
    output logic      [7:0] proc1VoltageCode
);
    // ==========================================================
    // idle levels: throttle released, inputs high, code zero
    initial begin
        proc1ThrottleInN = 1'b1;
        proc2ThrottleInN = 1'b1;
        generalInput     = 8'hff;
        proc1VoltageCode = 8'h00;
    end

    // ==========================================================
    // throttle pins are low while asserted
    task automatic setThrottle(input int ch, input logic active);
        if (ch == 1) begin
            proc1ThrottleInN = ~active;
        end else begin
            proc2ThrottleInN = ~active;
        end
    endtask : setThrottle

    // assert for exactly n sampling edges, caller sits just after an edge
    task automatic pulseThrottle(input int ch, input int n);
        setThrottle(ch, 1'b1);
        repeat (n) @(posedge clock);
        #1;
        setThrottle(ch, 1'b0);
    endtask : pulseThrottle

    // level pins
    task automatic setInputs(input logic [7:0] v);
        generalInput = v;
    endtask : setInputs

    task automatic setCode(input logic [7:0] v);
        proc1VoltageCode = v;
    endtask : setCode
endmodule : prt_proc_model

// file: dv/testbench.sv
// self-checking bench for the processor status monitor
`timescale 1ns/1ns
module testbench;
    import prt_pkg::*;
    // ==========================================================
    // stimulus and observation signals
    logic        clock              = 1'b0;
    logic        rst                = 1'b1;
    logic        regWrEn            = 1'b0;
    logic        regRdEn            = 1'b0;
    logic [7:0]  regAddr            = 8'h00;
    logic [7:0]  regWrData          = 8'h00;
    logic [15:0] stepLen            = 16'h0001;
    logic [1:0]  mode               = 2'd0;
    wire  logic  proc1ThrottleInN;
    wire  logic  proc2ThrottleInN;
    wire  logic [7:0] generalInput;
    wire  logic [7:0] proc1VoltageCode;
    wire  logic [7:0] regRdData;
    wire  logic  regRdValid;
    logic [7:0]  p1Cur              = 8'h00;
    logic [7:0]  p1Avg              = 8'h00;
    logic [7:0]  p2Cur              = 8'h00;
    logic [7:0]  p2Avg              = 8'h00;
    int          numErrors          = 0;
    int          comparisons        = 0;

    // 100 MHz clock
    always #5 clock = ~clock;

    // ==========================================================
    // instances
    prt_proc_model partner (
        .clock            (clock),
        .proc1ThrottleInN (proc1ThrottleInN),
        .proc2ThrottleInN (proc2ThrottleInN),
        .generalInput     (generalInput),
        .proc1VoltageCode (proc1VoltageCode)
    );

    prt_status_monitor dut (
        .clock              (clock),
        .rst                (rst),
        .proc1ThrottleInN   (proc1ThrottleInN),
        .proc2ThrottleInN   (proc2ThrottleInN),
        .generalInput       (generalInput),
        .proc1VoltageCode   (proc1VoltageCode),
        .intervalStepCycles (stepLen),
        .codeMode           (mode),
        .regWrEn            (regWrEn),
        .regRdEn            (regRdEn),
        .regAddr            (regAddr),
        .regWrData          (regWrData),
        .regRdData          (regRdData),
        .regRdValid         (regRdValid)
    );

    // ==========================================================
    // helpers
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask : step

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one-cycle write strobe
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        regWrEn   = 1'b1;
        regAddr   = addr;
        regWrData = data;
        step(1);
        regWrEn   = 1'b0;
    endtask : wr

    // read strobe, bounded wait for the valid pulse, then compare
    task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp, input string name);
        int n;
        regRdEn = 1'b1;
        regAddr = addr;
        step(1);
        regRdEn = 1'b0;
        n = 0;
        while (regRdValid !== 1'b1 && n < 4) begin
            step(1);
            n++;
        end
        if (regRdValid !== 1'b1) begin
            numErrors++;
            $display("[ERR] %s read valid never came", name);
            conclude();
        end
        check(name, regRdData, exp);
        step(1); // idle edge before the next strobe
    endtask : rdChk

    // code register layout per mode
    function automatic logic [7:0] layout(input logic [1:0] m, input logic [7:0] c);
        case (m)
            2'd0:    layout = {2'b00, c[5:0]};
            2'd3:    layout = {c[7:1], 1'b0};
            default: layout = {1'b0, c[6:0]};
        endcase
    endfunction : layout

    // new expectations after an interval end, then read all four values
    task automatic endInterval(input logic [7:0] cur1, input logic [7:0] cur2);
        p1Avg = 8'((9'(p1Avg) + 9'(cur1)) >> 1);
        p2Avg = 8'((9'(p2Avg) + 9'(cur2)) >> 1);
        p1Cur = cur1;
        p2Cur = cur2;
        rdChk(ADDR_P1_CUR, p1Cur, "p1 current");
        rdChk(ADDR_P1_AVG, p1Avg, "p1 average");
        rdChk(ADDR_P2_CUR, p2Cur, "p2 current");
        rdChk(ADDR_P2_AVG, p2Avg, "p2 average");
    endtask : endInterval

    // ==========================================================
    // main sequence
    initial begin
        step(16);
        rst = 1'b0;
        step(1);
        // reset values and refused accesses
        for (int a = 0; a < 6; a++) begin
            rdChk(ADDR_P1_CUR + 8'(a), RST_BYTE, "reset value");
        end
        wr(8'h70, 8'hff);
        rdChk(8'h70, 8'h00, "unmapped");
        wr(ADDR_P1_CUR, 8'haa);
        rdChk(ADDR_P1_CUR, 8'h00, "written current");
        // full throttle on p1, none on p2
        partner.setThrottle(1, 1'b1);
        wr(ADDR_P2_CUR, 8'h55);
        step(240);
        rdChk(ADDR_P1_CUR, p1Cur, "current before end");
        step(30);
        endInterval(8'hff, 8'h00);
        // p2 asserted for 100 samples mid-interval
        partner.setThrottle(1, 1'b0);
        wr(ADDR_P1_CUR, 8'h00);
        step(50);
        partner.pulseThrottle(2, 100);
        step(90);
        rdChk(ADDR_P2_AVG, p2Avg, "average before end");
        rdChk(ADDR_P2_CUR, p2Cur, "p2 current before end");
        step(30);
        endInterval(8'h00, 8'd100);
        // four cycles per step: two samples round up to one
        stepLen = 16'h0004;
        partner.setThrottle(1, 1'b1);
        wr(ADDR_P2_CUR, 8'h00);
        step(50);
        partner.pulseThrottle(2, 2);
        step(1000);
        endInterval(8'hff, 8'h01);
        // restart in mid-interval discards the partial count on p1
        stepLen = 16'h0001;
        wr(ADDR_P1_CUR, 8'h00);
        step(100);
        partner.setThrottle(1, 1'b0);
        wr(ADDR_P2_CUR, 8'h00);
        step(200);
        rdChk(ADDR_P1_CUR, p1Cur, "current after restart");
        step(70);
        endInterval(8'h00, 8'h00);
        // general input levels read inverted and live
        for (int i = 0; i < 4; i++) begin
            partner.setInputs(8'(32'h3ca5_ff00 >> (8 * i)));
            step(1);
            rdChk(ADDR_GPI, ~generalInput, "input levels");
        end
        // code layout in every mode
        partner.setCode(8'hd5);
        step(70);
        for (int m = 0; m < 4; m++) begin
            mode = 2'(m);
            rdChk(ADDR_P1_CODE, layout(2'(m), 8'hd5), "code layout");
        end
        mode = 2'd2;
        // short glitch is ignored, a held change loads
        partner.setCode(8'h2a);
        step(30);
        rdChk(ADDR_P1_CODE, layout(2'd2, 8'hd5), "code during glitch");
        partner.setCode(8'hd5);
        step(70);
        rdChk(ADDR_P1_CODE, layout(2'd2, 8'hd5), "code after glitch");
        partner.setCode(8'h2a);
        step(50);
        rdChk(ADDR_P1_CODE, layout(2'd2, 8'hd5), "code while settling");
        step(25);
        rdChk(ADDR_P1_CODE, layout(2'd2, 8'h2a), "code after hold");
        conclude();
    end
endmodule : testbench
